// >>> verilog/acx_pkg.sv
// shared constants and types of the analog channel exchange registers
package acx_pkg;

    // ======================================================
    // geometry
    localparam int NCHAN = 8;
    localparam int NCFG = 6;
    localparam int SYNC_STAGES = 3;

    // ======================================================
    // exchange word bit positions
    localparam int XB_STATUS = 0;
    localparam int XB_CMD = 1;
    localparam int XB_ADJUST = 2;
    localparam int XB_RECONF = 15;
    localparam logic [15:0] XW_RESET = 16'h0000;
    // module-level words never carry the adjust bit
    localparam logic [15:0] XW_MODULE_MASK = 16'h8003;

    // ======================================================
    // configuration word indices and fields
    localparam logic [2:0] CW_RANGE = 3'h0;
    localparam logic [2:0] CW_SCALE_MIN = 3'h1;
    localparam logic [2:0] CW_SCALE_MAX = 3'h2;
    localparam logic [2:0] CW_OVR_LOW = 3'h3;
    localparam logic [2:0] CW_OVR_HIGH = 3'h4;
    localparam logic [2:0] CW_TREAT = 3'h5;
    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam logic [15:0] RANGE_MASK_INPUT = 16'h003F;
    localparam logic [15:0] RANGE_MASK_TEMP = 16'h017F;
    localparam logic [15:0] TREAT_MASK_INPUT = 16'h0387;
    localparam logic [15:0] TREAT_MASK_TEMP_LO = 16'h03FE;
    localparam logic [15:0] TREAT_MASK_TEMP_HI = 16'h03E6;
    localparam int RB_KIND = 7;
    localparam int RB_UNIT_F = 6;
    localparam int RB_REJ60 = 8;
    localparam int TB_FAST = 0;
    localparam int TB_ENABLE = 1;
    localparam int TB_SENSOR = 2;
    localparam int TB_CJ_EXT_LO = 3;
    localparam int TB_CJ_HI_LO = 4;
    localparam int TB_CJ_EXT_HI = 5;
    localparam int TB_CJ_RSV_HI = 6;
    localparam int TB_USER_SCALE = 7;
    localparam int TB_OVR_LOW = 8;
    localparam int TB_OVR_HIGH = 9;

    // ======================================================
    // read port word indices
    localparam logic [3:0] RW_PENDING = 4'h0;
    localparam logic [3:0] RW_REPORT = 4'h1;
    localparam logic [3:0] RW_CFG0 = 4'h2;
    localparam logic [3:0] RW_CFG_LAST = 4'h7;

    typedef enum logic [2:0] {
        ACX_K_STATUS_READ = 3'b000,
        ACX_K_CMD_WRITE = 3'b001,
        ACX_K_PARAM_WRITE = 3'b010,
        ACX_K_PARAM_READ = 3'b011,
        ACX_K_PARAM_SAVE = 3'b100,
        ACX_K_PARAM_RESTORE = 3'b101,
        ACX_K_RECONFIG = 3'b110
    } acx_kind_t;

    typedef struct packed {
        logic valid;
        acx_kind_t kind;
        logic [2:0] chan;
    } acx_req_t;

    typedef struct packed {
        logic valid;
        acx_kind_t kind;
        logic [2:0] chan;
        logic err;
    } acx_ack_t;

    typedef struct packed {
        logic enabled;
        logic fast;
        logic sensor_mon;
        logic user_scale;
        logic ovr_low_en;
        logic ovr_high_en;
        logic unit_f;
        logic rej60;
    } acx_mode_t;

    // exchange-word bit owning a request kind
    function automatic logic [3:0] acx_class_bit(acx_kind_t k);
        unique case (k)
            ACX_K_STATUS_READ: acx_class_bit = 4'(XB_STATUS);
            ACX_K_CMD_WRITE: acx_class_bit = 4'(XB_CMD);
            ACX_K_RECONFIG: acx_class_bit = 4'(XB_RECONF);
            default: acx_class_bit = 4'(XB_ADJUST);
        endcase
    endfunction

endpackage

// >>> verilog/acx_regs.sv
// per-channel exchange bookkeeping and configuration words
//
// Summary of operation
// - pending bit 0 high while a status-word read is outstanding
// - pending bit 1 high while command parameters are transferred
// - pending bit 2 high during any adjust write, read, save or restore
// - pending bit 15 high while a channel reconfiguration runs
// - report bit 0 set when a status-word read failed
// - report bit 1 set when a command transfer was rejected
// - report bit 2 clear after good adjust exchange, set after failed one
// - report bit 15 set when a reconfiguration ended in error
// - parameter write sets its pending bit before the module reports
// - absent module: nothing forwarded, status pending stays 0, words live
// - module-level exchange words never show an adjust exchange
// - input range word: bits 0-5 range code, bit 7 always 0
// - configuration words 1-4: scale min, scale max, over-range low, high
// - input treatment: fast, enable, sensor, user scale, thresholds
// - temperature range: code, unit, bit 7 reads 1, 60 Hz rejection
// - temperature treatment bit 0 always 0; disable only in fast mode
// - channels 0-3 cold-junction: bit 3 external, bit 4 upper group
// - channels 4-7 cold-junction: bit 5 external, bit 6 not allowed
// - temperature treatment: sensor, user scale, over-range thresholds
`timescale 1ns/10ps

module acx_regs
    import acx_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // module pins
    input wire logic MOD_PRESENT,
    input wire logic TEMP_MODULE,
    // processor requests
    input wire acx_pkg::acx_req_t REQ,
    output logic REQ_READY,
    // forward to module and its acknowledge
    output acx_pkg::acx_req_t FWD,
    input wire acx_pkg::acx_ack_t ACK,
    // configuration load
    input wire logic CFG_WR,
    input wire logic [2:0] CFG_CHAN,
    input wire logic [2:0] CFG_IDX,
    input wire logic [15:0] CFG_DATA,
    input wire logic CFG_APPLY,
    // word read port
    input wire logic RD_MODULE,
    input wire logic [2:0] RD_CHAN,
    input wire logic [3:0] RD_IDX,
    output logic [15:0] RD_DATA,
    // decoded channel modes
    output acx_pkg::acx_mode_t CHAN_MODE [NCHAN]
);
    import acx_pkg::*;

    // ======================================================
    // pin synchronisers
    logic [SYNC_STAGES-1:0] pres_sync_reg;
    logic [SYNC_STAGES-1:0] temp_sync_reg;
    logic present_reg;
    logic temp_reg;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            pres_sync_reg <= '0;
            temp_sync_reg <= '0;
        end
        else
        begin
            pres_sync_reg <= {pres_sync_reg[1:0], MOD_PRESENT};
            temp_sync_reg <= {temp_sync_reg[1:0], TEMP_MODULE};
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            present_reg <= 1'b0;
            temp_reg <= 1'b0;
        end
        else
        begin
            if (pres_sync_reg[1] == pres_sync_reg[2])
                present_reg <= pres_sync_reg[2];
            if (temp_sync_reg[1] == temp_sync_reg[2])
                temp_reg <= temp_sync_reg[2];
        end
    end

    // ======================================================
    // request decode
    logic [15:0] pend_reg [NCHAN];
    logic [15:0] rpt_reg [NCHAN];
    logic [15:0] cfg_reg [NCHAN][NCFG];
    acx_ack_t ack_q_reg;
    logic [3:0] req_bit;
    logic req_take;
    logic req_busy;
    logic req_fwd;
    logic [3:0] ack_bit;
    logic [3:0] ackq_bit;
    logic cj_bad;
    logic cfg_take;
    logic cfg_fwd;

    // configuration apply owns the forward path in its cycle
    assign REQ_READY = ~CFG_APPLY;
    assign req_take = REQ.valid & REQ_READY & (REQ.kind != ACX_K_RECONFIG);
    assign req_bit = acx_class_bit(REQ.kind);
    assign req_busy = pend_reg[REQ.chan][req_bit];
    assign req_fwd = req_take & present_reg & ~req_busy;
    assign ack_bit = acx_class_bit(ACK.kind);
    assign ackq_bit = acx_class_bit(ack_q_reg.kind);

    // illegal cold-junction coding refuses the reconfiguration
    always_comb
    begin
        cj_bad = 1'b0;
        if (temp_reg)
        begin
            if (CFG_CHAN < 3'h4)
                cj_bad = cfg_reg[CFG_CHAN][CW_TREAT][TB_CJ_EXT_LO] &
                         cfg_reg[CFG_CHAN][CW_TREAT][TB_CJ_HI_LO];
            else
                cj_bad = cfg_reg[CFG_CHAN][CW_TREAT][TB_CJ_RSV_HI];
        end
    end

    assign cfg_take = CFG_APPLY & ~pend_reg[CFG_CHAN][XB_RECONF];
    assign cfg_fwd = cfg_take & present_reg & ~cj_bad;

    // ======================================================
    // forward to module
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            FWD <= '0;
        else if (cfg_fwd)
            FWD <= '{valid: 1'b1, kind: ACX_K_RECONFIG, chan: CFG_CHAN};
        else if (req_fwd)
            FWD <= '{valid: 1'b1, kind: REQ.kind, chan: REQ.chan};
        else
            FWD <= '{valid: 1'b0, kind: ACX_K_STATUS_READ, chan: 3'h0};
    end

    // acknowledge is held one cycle so the report lands first
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            ack_q_reg <= '0;
        else
            ack_q_reg <= ACK;
    end

    // ======================================================
    // exchange-in-progress words
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int c = 0; c < NCHAN; c++)
                pend_reg[c] <= XW_RESET;
        end
        else
        begin
            if (ack_q_reg.valid)
                pend_reg[ack_q_reg.chan][ackq_bit] <= 1'b0;
            if (!present_reg)
            begin
                for (int c = 0; c < NCHAN; c++)
                    pend_reg[c][XB_STATUS] <= 1'b0;
            end
            // set wins over clear
            if (req_fwd)
                pend_reg[REQ.chan][req_bit] <= 1'b1;
            if (cfg_fwd)
                pend_reg[CFG_CHAN][XB_RECONF] <= 1'b1;
        end
    end

    // ======================================================
    // exchange report words
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int c = 0; c < NCHAN; c++)
                rpt_reg[c] <= XW_RESET;
        end
        else
        begin
            if (ACK.valid && pend_reg[ACK.chan][ack_bit])
                rpt_reg[ACK.chan][ack_bit] <= ACK.err;
            // refused or unforwarded requests report a failure
            if (req_take && !req_fwd)
                rpt_reg[REQ.chan][req_bit] <= 1'b1;
            if (cfg_take && !cfg_fwd)
                rpt_reg[CFG_CHAN][XB_RECONF] <= 1'b1;
        end
    end

    // ======================================================
    // configuration words
    function automatic logic [15:0] cfg_clean(logic temp, logic [2:0] ch,
                                              logic [2:0] idx,
                                              logic [15:0] d);
        logic [15:0] r;
        r = d;
        if (idx == CW_RANGE)
        begin
            if (temp)
            begin
                r = d & RANGE_MASK_TEMP;
                r[RB_KIND] = 1'b1;
            end
            else
                r = d & RANGE_MASK_INPUT;
        end
        else if (idx == CW_TREAT)
        begin
            if (!temp)
                r = d & TREAT_MASK_INPUT;
            else if (ch < 3'h4)
                r = d & TREAT_MASK_TEMP_LO;
            else
                r = d & TREAT_MASK_TEMP_HI;
        end
        return r;
    endfunction

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int c = 0; c < NCHAN; c++)
                for (int w = 0; w < NCFG; w++)
                    cfg_reg[c][w] <= CW_RESET;
        end
        else if (CFG_WR && (CFG_IDX <= CW_TREAT))
            cfg_reg[CFG_CHAN][CFG_IDX] <=
                cfg_clean(temp_reg, CFG_CHAN, CFG_IDX, CFG_DATA);
    end

    // ======================================================
    // decoded channel modes
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int c = 0; c < NCHAN; c++)
                CHAN_MODE[c] <= '0;
        end
        else
        begin
            for (int c = 0; c < NCHAN; c++)
            begin
                // temperature channels can only be disabled in fast mode
                CHAN_MODE[c].enabled <= cfg_reg[c][CW_TREAT][TB_ENABLE] |
                    (temp_reg & ~cfg_reg[c][CW_TREAT][TB_FAST]);
                CHAN_MODE[c].fast <= cfg_reg[c][CW_TREAT][TB_FAST];
                CHAN_MODE[c].sensor_mon <= cfg_reg[c][CW_TREAT][TB_SENSOR];
                CHAN_MODE[c].user_scale <=
                    cfg_reg[c][CW_TREAT][TB_USER_SCALE];
                CHAN_MODE[c].ovr_low_en <= cfg_reg[c][CW_TREAT][TB_OVR_LOW];
                CHAN_MODE[c].ovr_high_en <= cfg_reg[c][CW_TREAT][TB_OVR_HIGH];
                CHAN_MODE[c].unit_f <=
                    temp_reg & cfg_reg[c][CW_RANGE][RB_UNIT_F];
                CHAN_MODE[c].rej60 <=
                    temp_reg & cfg_reg[c][CW_RANGE][RB_REJ60];
            end
        end
    end

    // ======================================================
    // word read port, one cycle latency
    logic [15:0] mod_pend;
    logic [15:0] mod_rpt;

    always_comb
    begin
        mod_pend = '0;
        mod_rpt = '0;
        for (int c = 0; c < NCHAN; c++)
        begin
            mod_pend = mod_pend | pend_reg[c];
            mod_rpt = mod_rpt | rpt_reg[c];
        end
        mod_pend = mod_pend & XW_MODULE_MASK;
        mod_rpt = mod_rpt & XW_MODULE_MASK;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            RD_DATA <= '0;
        else if (RD_IDX == RW_PENDING)
            RD_DATA <= RD_MODULE ? mod_pend : pend_reg[RD_CHAN];
        else if (RD_IDX == RW_REPORT)
            RD_DATA <= RD_MODULE ? mod_rpt : rpt_reg[RD_CHAN];
        else if (!RD_MODULE && RD_IDX <= RW_CFG_LAST)
            RD_DATA <= cfg_reg[RD_CHAN][3'(RD_IDX - RW_CFG0)];
        else
            RD_DATA <= '0;
    end

    // ======================================================
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    param_pend_a: assert property (
        req_fwd && REQ.kind == ACX_K_PARAM_WRITE |=>
            pend_reg[$past(REQ.chan)][XB_ADJUST] && FWD.valid &&
            FWD.kind == ACX_K_PARAM_WRITE)
        else $error("param write did not raise adjust pending");

    absent_nofwd_a: assert property (
        !present_reg |=> !FWD.valid)
        else $error("request forwarded to absent module");

    apply_busy_a: assert property (
        CFG_APPLY && pend_reg[CFG_CHAN][XB_RECONF] |=> !FWD.valid)
        else $error("reconfiguration forwarded while one is pending");

    absent_sts_a: assert property (
        !present_reg |=> pend_reg[$past(REQ.chan)][XB_STATUS] == 1'b0)
        else $error("status pending set while module absent");

    report_first_a: assert property (
        ACK.valid && pend_reg[ACK.chan][ack_bit] |=>
            rpt_reg[$past(ACK.chan)][$past(ack_bit)] == $past(ACK.err) &&
            pend_reg[$past(ACK.chan)][$past(ack_bit)]
            ##1 !pend_reg[$past(ACK.chan, 2)][$past(ack_bit, 2)])
        else $error("report and pending out of order");

    adjust_rej_a: assert property (
        req_take && req_busy && req_bit == 4'(XB_ADJUST) |=>
            rpt_reg[$past(REQ.chan)][XB_ADJUST] && !FWD.valid)
        else $error("concurrent adjust request not faulted");

    input_kind_a: assert property (
        CFG_WR && CFG_IDX == CW_RANGE && !temp_reg |=>
            !cfg_reg[$past(CFG_CHAN)][CW_RANGE][RB_KIND])
        else $error("input range word bit 7 not zero");

    temp_kind_a: assert property (
        CFG_WR && CFG_IDX == CW_RANGE && temp_reg |=>
            cfg_reg[$past(CFG_CHAN)][CW_RANGE][RB_KIND])
        else $error("temperature range word bit 7 not one");

    temp_std_a: assert property (
        CFG_WR && CFG_IDX == CW_TREAT && temp_reg |=>
            !cfg_reg[$past(CFG_CHAN)][CW_TREAT][TB_FAST])
        else $error("temperature channel left in fast mode");

    cold_junc_a: assert property (
        cfg_take && cj_bad |=>
            rpt_reg[$past(CFG_CHAN)][XB_RECONF] && !FWD.valid)
        else $error("bad cold-junction coding not refused");

    module_adj_a: assert property (
        RD_MODULE && RD_IDX <= RW_REPORT |=> !RD_DATA[XB_ADJUST])
        else $error("module word shows adjust exchange");

    fwd_param_c: cover property (req_fwd && REQ.kind == ACX_K_PARAM_WRITE);
    ack_err_c: cover property (ACK.valid && ACK.err);
    reconf_done_c: cover property (ack_q_reg.valid &&
                                   ack_q_reg.kind == ACX_K_RECONFIG);
    adjust_rej_c: cover property (req_take && req_busy);

endmodule

// >>> dv/acx_module_model.sv
// far-side analog module model answering forwarded exchange requests
`timescale 1ns/10ps

module acx_module_model
    import acx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // forwarded requests and acknowledge
    input wire acx_pkg::acx_req_t fwd,
    output acx_pkg::acx_ack_t ack,
    // bench controls: stall answers, answer with failure
    input wire logic hold,
    input wire logic fail
);
    acx_req_t pend_q[$];
    acx_req_t head;
    logic [3:0] idle_pat;

    // ======================================================
    // answer in order, one per cycle, while not stalled
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q.delete();
            ack <= '0;
            idle_pat <= 4'h0;
        end
        else
        begin
            idle_pat <= idle_pat + 4'h1;
            // idle fields wander so no stale value looks valid
            ack <= {1'b0, idle_pat[2:0], ~idle_pat[2:0], idle_pat[3]};
            if (!hold && pend_q.size() > 0)
            begin
                head = pend_q.pop_front();
                ack <= {1'b1, head.kind, head.chan, fail};
            end
            if (fwd.valid)
                pend_q.push_back(fwd);
        end
    end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the analog channel exchange registers
`timescale 1ns/10ps

module testbench;
    import acx_pkg::*;
    logic MCLK, RST, MOD_PRESENT, TEMP_MODULE, REQ_READY;
    logic CFG_WR, CFG_APPLY, RD_MODULE, hold, fail, mon_has;
    acx_req_t REQ, FWD;
    acx_ack_t ACK;
    logic [2:0] CFG_CHAN, CFG_IDX, RD_CHAN, ch;
    logic [15:0] CFG_DATA, RD_DATA, d, e, rg, tr, mon_e;
    logic [3:0] RD_IDX;
    acx_mode_t CHAN_MODE [NCHAN];
    acx_kind_t kd;
    logic [15:0] pend_e [NCHAN];
    logic [15:0] rpt_e [NCHAN];
    logic [15:0] exp_q[$];
    acx_req_t fwd_q[$];
    int num_errors, samples_checked;

    acx_regs uut (.MCLK(MCLK), .RST(RST), .MOD_PRESENT(MOD_PRESENT),
        .TEMP_MODULE(TEMP_MODULE), .REQ(REQ), .REQ_READY(REQ_READY),
        .FWD(FWD), .ACK(ACK), .CFG_WR(CFG_WR), .CFG_CHAN(CFG_CHAN),
        .CFG_IDX(CFG_IDX), .CFG_DATA(CFG_DATA), .CFG_APPLY(CFG_APPLY),
        .RD_MODULE(RD_MODULE), .RD_CHAN(RD_CHAN), .RD_IDX(RD_IDX),
        .RD_DATA(RD_DATA), .CHAN_MODE(CHAN_MODE));
    acx_module_model far_end (.clk(MCLK), .rst(RST), .fwd(FWD), .ack(ACK),
        .hold(hold), .fail(fail));

    initial
    begin
        MCLK = 0;
        forever #12.5 MCLK = ~MCLK;
    end

    // ======================================================
    // helpers
    task automatic tick(int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic cmp(string what, logic [15:0] ex, logic [15:0] seen);
        samples_checked++;
        if (seen !== ex)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, ex, seen);
        end
    endtask

    task automatic rd(logic m, logic [2:0] c, logic [3:0] i, logic [15:0] ex);
        RD_MODULE = m;
        RD_CHAN = c;
        RD_IDX = i;
        exp_q.push_back(ex);
        tick(1);
    endtask

    // requests spaced two cycles so valid drops between them
    task automatic req(acx_kind_t k, logic [2:0] c, logic fwd_ok);
        REQ = acx_req_t'{1'b1, k, c};
        if (fwd_ok)
            fwd_q.push_back(acx_req_t'{1'b1, k, c});
        tick(1);
        REQ.valid = 1'b0;
        tick(1);
    endtask

    task automatic cfg(logic [2:0] c, logic [2:0] i, logic [15:0] v);
        CFG_WR = 1;
        CFG_CHAN = c;
        CFG_IDX = i;
        CFG_DATA = v;
        tick(1);
        CFG_WR = 0;
    endtask

    task automatic apply(logic [2:0] c, logic [15:0] v, logic ok);
        cfg(c, 3'h5, v);
        CFG_APPLY = 1;
        if (ok)
            fwd_q.push_back(acx_req_t'{1'b1, ACX_K_RECONFIG, c});
        #1;
        cmp("REQ_READY", 16'h0000, {15'h0000, REQ_READY});
        tick(1);
        CFG_APPLY = 0;
        tick(1);
    endtask

    function automatic int cb(acx_kind_t k);
        if (k == ACX_K_STATUS_READ) return 0;
        if (k == ACX_K_CMD_WRITE) return 1;
        if (k == ACX_K_RECONFIG) return 15;
        return 2;
    endfunction

    function automatic logic [15:0] sani(logic t, logic [2:0] c, int i,
        logic [15:0] v);
        if (i == 0) return t ? ((v & 16'h017F) | 16'h0080) : (v & 16'h003F);
        if (i == 5)
            return !t ? (v & 16'h0387)
                : (c < 4) ? (v & 16'h03FE) : (v & 16'h03E6);
        return v;
    endfunction

    task automatic close_out();
        cmp("FWD_LEFT", 16'h0000, 16'(fwd_q.size()));
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ======================================================
    // monitor: read data one cycle after its address, every forward
    always @(posedge MCLK)
    begin
        mon_has = exp_q.size() > 0;
        if (mon_has)
            mon_e = exp_q.pop_front();
        #3;
        if (mon_has)
            cmp("RD_DATA", mon_e, RD_DATA);
        if (FWD.valid === 1'b1)
            cmp("FWD", (fwd_q.size() > 0) ? {9'h000, fwd_q.pop_front()}
                : 16'h0000, {9'h000, FWD});
    end

    initial
    begin
        #(25 * 6000);
        num_errors++;
        $display("watchdog expired");
        close_out();
    end

    // ======================================================
    // main sequence
    initial
    begin
        RST = 1;
        MOD_PRESENT = 0;
        TEMP_MODULE = 0;
        REQ = '0;
        CFG_WR = 0;
        CFG_APPLY = 0;
        CFG_CHAN = 3'h0;
        CFG_IDX = 3'h0;
        CFG_DATA = 16'h0000;
        RD_MODULE = 0;
        RD_CHAN = 3'h0;
        RD_IDX = 4'h0;
        hold = 0;
        fail = 0;
        foreach (pend_e[i])
        begin
            pend_e[i] = 16'h0000;
            rpt_e[i] = 16'h0000;
        end
        void'($urandom(32'h6C95));
        tick(16);
        RST = 0;
        tick(8);
        for (int i = 0; i < 8; i++)
            rd(1'b0, 3'h2, 4'(i), 16'h0000);
        $display("test reset values done");

        // module absent: refused locally, nothing forwarded
        req(ACX_K_STATUS_READ, 3'h0, 1'b0);
        rpt_e[0][0] = 1;
        rd(1'b0, 3'h0, RW_PENDING, pend_e[0]);
        rd(1'b0, 3'h0, RW_REPORT, rpt_e[0]);
        $display("test absent module done");

        MOD_PRESENT = 1;
        tick(8);
        for (int k = 0; k < 7; k++)
        begin
            kd = acx_kind_t'(k);
            ch = 3'($urandom_range(7));
            fail = 1'($urandom_range(1));
            hold = 1;
            req(kd, ch, k != 6);
            if (k != 6)
                pend_e[ch][cb(kd)] = 1;
            rd(1'b0, ch, RW_PENDING, pend_e[ch]);
            rd(1'b1, 3'h0, RW_PENDING, pend_e[ch] & 16'h8003);
            hold = 0;
            tick(6);
            if (k != 6)
            begin
                rpt_e[ch][cb(kd)] = fail;
                pend_e[ch][cb(kd)] = 0;
            end
            rd(1'b0, ch, RW_PENDING, pend_e[ch]);
            rd(1'b0, ch, RW_REPORT, rpt_e[ch]);
        end
        $display("test request kinds done");

        // overlapping adjust requests on one channel
        hold = 1;
        fail = 0;
        REQ = acx_req_t'{1'b1, ACX_K_PARAM_WRITE, 3'h5};
        fwd_q.push_back(REQ);
        tick(1);
        REQ = acx_req_t'{1'b1, ACX_K_PARAM_RESTORE, 3'h5};
        tick(1);
        REQ.valid = 1'b0;
        tick(1);
        pend_e[5][2] = 1;
        rpt_e[5][2] = 1;
        rd(1'b0, 3'h5, RW_REPORT, rpt_e[5]);
        rd(1'b0, 3'h5, RW_PENDING, pend_e[5]);
        hold = 0;
        tick(6);
        rpt_e[5][2] = 0;
        pend_e[5][2] = 0;
        rd(1'b0, 3'h5, RW_REPORT, rpt_e[5]);
        $display("test overlapping adjust done");

        // configuration words in both channel layouts
        for (int t = 0; t < 2; t++)
        begin
            TEMP_MODULE = 1'(t);
            tick(8);
            for (int c = 0; c < 8; c++)
            begin
                for (int i = 0; i < 6; i++)
                begin
                    d = 16'($urandom);
                    e = sani(1'(t), 3'(c), i, d);
                    if (i == 0) rg = e;
                    if (i == 5) tr = e;
                    cfg(3'(c), 3'(i), d);
                    rd(1'b0, 3'(c), 4'(i + 2), e);
                end
                cmp("CHAN_MODE", {8'h00, 1'(t) | tr[1], tr[0], tr[2], tr[7],
                    tr[8], tr[9], rg[6], rg[8]},
                    {8'h00, CHAN_MODE[c]});
            end
        end
        rd(1'b0, 3'h0, 4'hF, 16'h0000);
        $display("test configuration words done");

        // reconfiguration: illegal compensation pair, then a good one
        apply(3'h1, 16'h0018, 1'b0);
        rpt_e[1][15] = 1;
        rd(1'b0, 3'h1, RW_REPORT, rpt_e[1]);
        hold = 1;
        fail = 1;
        apply(3'h6, 16'h0020, 1'b1);
        pend_e[6][15] = 1;
        rd(1'b0, 3'h6, RW_PENDING, pend_e[6]);
        // a second apply while one is pending must be ignored
        apply(3'h6, 16'h0020, 1'b0);
        rd(1'b0, 3'h6, RW_REPORT, rpt_e[6]);
        hold = 0;
        tick(6);
        pend_e[6][15] = 0;
        rpt_e[6][15] = 1;
        rd(1'b0, 3'h6, RW_PENDING, pend_e[6]);
        rd(1'b0, 3'h6, RW_REPORT, rpt_e[6]);
        e = 16'h0000;
        foreach (rpt_e[i])
            e = e | rpt_e[i];
        rd(1'b1, 3'h0, RW_REPORT, e & 16'h8003);
        tick(3);
        $display("test reconfiguration done");
        close_out();
    end
endmodule
